// File: serial_rx_idle.v
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "serial_rx_idle_map.vh"

// What this block does
// - Line is idle after 10 one bit-times, 11 in nine-bit format.
// - Short idle mode counts ones anywhere, including inside a frame.
// - Long idle mode starts counting ones only after a stop bit.
// - Idle type bit selects short or long; idle flag sets at length.
// - Idle interrupt enable raises the interrupt while idle flag is set.
// - Idle flag clears by status read with flag set, then data read.
// - Idle flag is not set again until a frame sets receive full.
// - Writing one to sleep request enters wakeup mode, ignoring traffic.
// - While sleep request is set, only a waking address frame sets receiver status flags.
// - Software writing zero clears sleep; hardware clears it on wakeup.
// - Wake select zero is idle-line wakeup, one is address-mark wakeup.
// - Idle-line wakeup clears sleep request when an idle line is seen.
// - Frame MSB one marks an address frame, zero marks a data frame.
// - Address frame wakes receiver, loads data and sets receive full.
// - Ninth-bit select adds a ninth data bit and lengthens idle time.
// - Status then data read clears all receiver status flags.
module serial_rx_idle
(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire rxd,
	input wire frame_done,
	input wire [8:0] frame_data,
	input wire frame_noise,
	input wire frame_framing_err,
	input wire frame_parity_err,
	output reg irq
);

	// Required idle length for the selected data format
	function [3:0] idle_len;
		input ninth;
		begin
			idle_len = ninth ? `IDLE_LEN_9 : `IDLE_LEN_8;
		end
	endfunction

	reg rxd_meta_r;
	reg rxd_r;
	reg [15:0] baud_r;
	reg [15:0] div_r;
	reg bit_tick;
	reg [3:0] ones_r;
	reg long_go_r;
	reg idle_arm_r;
	reg [`CT_WIDTH-1:0] ctl_r;
	reg [8:0] serial_data_reg;
	reg receive_full_flag;
	reg idle_flag_r;
	reg overrun_r;
	reg noise_r;
	reg framing_r;
	reg parity_r;
	reg clr_arm_r;
	reg [`IQ_WIDTH-1:0] iq_stat_r;
	reg [`IQ_WIDTH-1:0] iq_en_r;
	reg aw_held_r;
	reg w_held_r;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	wire idle_type_select = ctl_r[`CT_IDLE_TYPE];
	wire idle_irq_enable = ctl_r[`CT_IDLE_IRQ];
	wire sleep_request = ctl_r[`CT_SLEEP];
	wire wake_select = ctl_r[`CT_WAKE];
	wire ninth_sel = ctl_r[`CT_NINTH];
	wire [3:0] need_len = idle_len(ninth_sel);

	// Bit-time sense and idle detection
	wire counting = !idle_type_select || long_go_r;
	wire idle_hit = bit_tick && rxd_r && counting && (ones_r == need_len - 4'h1);
	wire addr_mark = ninth_sel ? frame_data[8] : frame_data[7];
	wire addr_wake = frame_done && sleep_request && wake_select && addr_mark;
	wire line_wake = idle_hit && sleep_request && !wake_select;
	// Flags are blocked while asleep; an address frame wakes and lands normally
	wire rx_take = frame_done && (!sleep_request || addr_wake);
	wire load = rx_take && !receive_full_flag;
	wire ovr_set = rx_take && receive_full_flag;
	wire idle_set = idle_hit && !sleep_request && idle_arm_r;

	// Bus side decode
	wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	wire rd_go = s_axi_arready && s_axi_arvalid;
	wire wr_ctl = wr_go && awaddr_q == `OFS_CONTROL && wstrb_q[0];
	wire rd_status = rd_go && s_axi_araddr == `OFS_STATUS;
	wire rd_data = rd_go && s_axi_araddr == `OFS_DATA;
	wire flag_clr = rd_data && clr_arm_r;
	wire any_flag = receive_full_flag | idle_flag_r | overrun_r | noise_r | framing_r | parity_r;

	// Two-flop synchroniser on the line pin
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rxd_meta_r <= 1'b1;
			rxd_r <= 1'b1;
		end
		else
		begin
			rxd_meta_r <= rxd;
			rxd_r <= rxd_meta_r;
		end
	end

	// Bit-time enable; not phase-locked to frames, which only shifts idle by a tick
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_r <= 16'h0000;
			bit_tick <= 1'b0;
		end
		else if (div_r >= baud_r)
		begin
			div_r <= 16'h0000;
			bit_tick <= 1'b1;
		end
		else
		begin
			div_r <= div_r + 16'h0001;
			bit_tick <= 1'b0;
		end
	end

	// Idle bit-time counter
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ones_r <= 4'h0;
			long_go_r <= 1'b0;
		end
		else
		begin
			// long mode armed by stop bit
			if (frame_done)
				long_go_r <= 1'b1;
			else if (bit_tick && !rxd_r)
				long_go_r <= 1'b0;
			if (bit_tick && !rxd_r)
				ones_r <= 4'h0;
			else if (bit_tick && counting && ones_r < need_len)
				ones_r <= ones_r + 4'h1;
		end
	end

	// Receiver status flags; a set in the clearing cycle wins
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			receive_full_flag <= 1'b0;
			idle_flag_r <= 1'b0;
			overrun_r <= 1'b0;
			noise_r <= 1'b0;
			framing_r <= 1'b0;
			parity_r <= 1'b0;
			idle_arm_r <= 1'b1;
			clr_arm_r <= 1'b0;
			serial_data_reg <= 9'h000;
		end
		else
		begin
			// data lands only when awake or address-woken
			if (load)
				serial_data_reg <= frame_data;
			// status then data read clears all flags
			receive_full_flag <= (receive_full_flag & ~flag_clr) | load;
			overrun_r <= (overrun_r & ~flag_clr) | ovr_set;
			noise_r <= (noise_r & ~flag_clr) | (load & frame_noise);
			framing_r <= (framing_r & ~flag_clr) | (load & frame_framing_err);
			parity_r <= (parity_r & ~flag_clr) | (load & frame_parity_err);
			// idle flag sets at length, clears by read pair
			idle_flag_r <= (idle_flag_r & ~flag_clr) | idle_set;
			// rearm only after a frame sets receive full
			if (load)
				idle_arm_r <= 1'b1;
			else if (idle_set)
				idle_arm_r <= 1'b0;
			// Status read arms the clear only when something is pending
			if (rd_status)
				clr_arm_r <= any_flag;
			else if (rd_data)
				clr_arm_r <= 1'b0;
		end
	end

	// Control, baud and interrupt registers
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctl_r <= `CT_RESET;
			baud_r <= `BAUD_RESET;
			iq_en_r <= {`IQ_WIDTH{1'b0}};
			iq_stat_r <= {`IQ_WIDTH{1'b0}};
		end
		else
		begin
			if (wr_ctl)
				ctl_r <= wdata_q[`CT_WIDTH-1:0];
			if (line_wake || addr_wake)
				ctl_r[`CT_SLEEP] <= 1'b0;
			if (wr_go && awaddr_q == `OFS_BAUD)
			begin
				if (wstrb_q[0])
					baud_r[7:0] <= wdata_q[7:0];
				if (wstrb_q[1])
					baud_r[15:8] <= wdata_q[15:8];
			end
			if (wr_go && awaddr_q == `OFS_IRQ_EN && wstrb_q[0])
				iq_en_r <= wdata_q[`IQ_WIDTH-1:0];
			// Sticky events; a new event beats a same-cycle clear
			iq_stat_r <= (iq_stat_r & ~((wr_go && awaddr_q == `OFS_IRQ_CLR && wstrb_q[0]) ?
				wdata_q[`IQ_WIDTH-1:0] : {`IQ_WIDTH{1'b0}})) | {ovr_set, idle_set, load};
		end
	end

	// Interrupt line, registered
	always @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			// idle enable gates the idle flag onto the line
			irq <= |(iq_stat_r & iq_en_r) | (idle_irq_enable & idle_flag_r)
				| (ctl_r[`CT_FULL_IRQ] & receive_full_flag);
	end

	// Write channels: address and data taken in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awready && s_axi_awvalid)
			begin
				aw_held_r <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			else if (!aw_held_r && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (s_axi_wready && s_axi_wvalid)
			begin
				w_held_r <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			else if (!w_held_r && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (wr_go)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_q)
					`OFS_CONTROL, `OFS_BAUD, `OFS_IRQ_EN, `OFS_IRQ_CLR:
						s_axi_bresp <= `RESP_OKAY;
					`OFS_STATUS, `OFS_DATA, `OFS_IRQ_STAT:
						s_axi_bresp <= `RESP_OKAY;
					default:
						s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel; status and data reads have clearing side effects
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case (s_axi_araddr)
				`OFS_STATUS:
					s_axi_rdata <= {25'h0000000, sleep_request, parity_r, framing_r,
						noise_r, overrun_r, idle_flag_r, receive_full_flag};
				`OFS_CONTROL:
					s_axi_rdata <= {26'h0000000, ctl_r};
				`OFS_DATA:
					s_axi_rdata <= {23'h000000, serial_data_reg};
				`OFS_BAUD:
					s_axi_rdata <= {16'h0000, baud_r};
				`OFS_IRQ_STAT:
					s_axi_rdata <= {29'h00000000, iq_stat_r};
				`OFS_IRQ_EN:
					s_axi_rdata <= {29'h00000000, iq_en_r};
				`OFS_IRQ_CLR:
					s_axi_rdata <= 32'h00000000;
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

endmodule

// File: serial_rx_idle_map.vh
`ifndef SERIAL_RX_IDLE_MAP_VH
`define SERIAL_RX_IDLE_MAP_VH

// Register byte offsets
`define OFS_STATUS 8'h00
`define OFS_CONTROL 8'h04
`define OFS_DATA 8'h08
`define OFS_BAUD 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_EN 8'h14
`define OFS_IRQ_CLR 8'h18

// Status register fields
`define ST_FULL 0
`define ST_IDLE 1
`define ST_OVERRUN 2
`define ST_NOISE 3
`define ST_FRAMING 4
`define ST_PARITY 5
`define ST_SLEEP 6

// Control register fields
`define CT_IDLE_TYPE 0
`define CT_IDLE_IRQ 1
`define CT_SLEEP 2
`define CT_WAKE 3
`define CT_NINTH 4
`define CT_FULL_IRQ 5
`define CT_WIDTH 6
`define CT_RESET 6'h00

// Interrupt status fields
`define IQ_FULL 0
`define IQ_IDLE 1
`define IQ_OVERRUN 2
`define IQ_WIDTH 3

// Idle line lengths in bit-times
`define IDLE_LEN_8 4'hA
`define IDLE_LEN_9 4'hB

// Bit-time length minus one, in clock cycles, after reset
`define BAUD_RESET 16'h0208

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: far_line.sv
`timescale 1ns/1ps
// Remote sender on the shared line, plus the frame receiver's strobe
module far_line
#(
	parameter int BT = 4
)
(
	input wire aclk,
	output logic rxd,
	output logic frame_done,
	output logic [8:0] frame_data,
	output logic frame_noise,
	output logic frame_framing_err,
	output logic frame_parity_err
);
	// Line rests at mark; clean frames only
	initial
	begin
		rxd = 1'b1;
		frame_done = 1'b0;
		frame_data = 9'h155;
		frame_noise = 1'b0;
		frame_framing_err = 1'b0;
		frame_parity_err = 1'b0;
	end
	// Drive one level for n bit-times
	task hold(input logic v, input int n);
		rxd <= v;
		repeat (n * BT) @(posedge aclk);
	endtask
	// first frame addresses
	// Start bit, data LSB first, stop bit, then the strobe
	task frame(input logic [8:0] v, input int nb);
		hold(1'b0, 1);
		for (int i = 0; i < nb; i++)
			hold(v[i], 1);
		hold(1'b1, 1);
		frame_data <= v;
		frame_done <= 1'b1;
		@(posedge aclk);
		frame_done <= 1'b0;
		// Stale data is not left on the bus
		frame_data <= ~v;
	endtask
	// idle between messages
	// A run of ones closed by zeros, and led by zeros when lead is set, so the count is exact
	task ones(input int n, input logic lead);
		if (lead)
			hold(1'b0, 2);
		// An empty run must not drive the line twice in one time step
		if (n > 0)
			hold(1'b1, n);
		hold(1'b0, 2);
		rxd <= 1'b1;
	endtask
endmodule

// File: serial_rx_idle_properties.sv
`timescale 1ns/1ps
`include "serial_rx_idle_map.vh"
// Bus timing seen from the block's pins
module serial_rx_idle_properties
(
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [7:0] ra_r;
	// Keep the taken read address to judge its answer
	always @(posedge aclk)
		if (s_axi_arvalid && s_axi_arready)
			ra_r <= s_axi_araddr;
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_WR_ANSWER: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	AST_RD_ANSWER: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read answer late");
	AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	AST_W_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	AST_R_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	AST_UNMAPPED: assert property (s_axi_rvalid && ra_r > `OFS_IRQ_CLR |->
		s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("hole answered");
	AST_RESET_QUIET: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy after reset");
endmodule
bind serial_rx_idle serial_rx_idle_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .irq);

// File: serial_rx_idle_test.sv
`timescale 1ns/1ps
`include "serial_rx_idle_map.vh"
module serial_rx_idle_test;
	localparam int BT = 4;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, e_full = 0, e_idle = 0, e_sleep = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic rxd, frame_done, frame_noise, frame_framing_err, frame_parity_err;
	logic [8:0] frame_data, v9;
	int bad_count = 0, tests_run = 0, cyc = 0;
	always #25 aclk = ~aclk;
	serial_rx_idle u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .frame_done, .frame_data,
		.frame_noise, .frame_framing_err, .frame_parity_err, .irq);
	far_line #(.BT(BT)) u_far (.aclk, .rxd, .frame_done, .frame_data, .frame_noise,
		.frame_framing_err, .frame_parity_err);
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Address and data offered together, each released once taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		@(posedge aclk);
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w)
		begin
			@(negedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task stat;
		rd(`OFS_STATUS);
		chk(d, {25'h0, e_sleep, 4'h0, e_idle, e_full});
	endtask
	// Status then data read empties the flags
	task clr;
		stat;
		rd(`OFS_DATA);
		e_full = 0;
		e_idle = 0;
	endtask
	task ctrl(input logic [31:0] v);
		wr(`OFS_CONTROL, v);
		e_sleep = v[`CT_SLEEP];
	endtask
	// irq is registered, so give it time to settle
	task ckirq(input logic e);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard, well above the expected run
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			bad_count++;
			test_done;
		end
	end
	initial
	begin
		void'($urandom(32'haeda2d2d));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`OFS_CONTROL);
		chk(d, {26'h0, `CT_RESET});
		rd(`OFS_BAUD);
		chk(d, {16'h0, `BAUD_RESET});
		rd(8'h1C);
		chk({d[29:0], r}, {30'h0, `RESP_SLVERR});
		wr(`OFS_STATUS, 32'hFF);
		chk({30'h0, r}, {30'h0, `RESP_OKAY});
		wr(`OFS_BAUD, BT - 1);
		$display("registers done");
		ctrl(32'h2);
		repeat (12 * BT) @(posedge aclk);
		e_idle = 1;
		stat; // first idle
		ckirq(1); // idle irq
		clr;
		stat; // flag cleared
		ckirq(0); // irq drops
		u_far.ones(12, 1);
		stat; // no second idle
		$display("idle flag done");
		for (int k = 0; k < 2; k++)
		begin
			ctrl(k ? 32'h2 : 32'h3);
			u_far.frame(9'h0FF, 8);
			u_far.ones(8, 0);
			e_full = 1;
			e_idle = k;
			stat; // mode choice
			clr;
			chk(d, 32'hFF); // data kept
		end
		$display("idle modes done");
		for (int k = 0; k < 2; k++)
		begin
			ctrl(k ? 32'h12 : 32'h2);
			u_far.frame(9'h055, 8 + k);
			e_full = 1;
			u_far.ones(9 + k, 1);
			stat; // one short
			u_far.ones(11 + k, 1);
			e_idle = 1;
			stat; // one past length
			clr;
		end
		$display("idle length done");
		ctrl(32'h4);
		stat; // sleep entered
		u_far.frame(9'h012, 8);
		stat; // frame ignored
		repeat (12 * BT) @(posedge aclk);
		e_sleep = 0;
		stat; // idle wakes
		ctrl(32'hD);
		u_far.frame(9'h005, 8);
		stat; // data frame sleeps
		v9 = {2'b01, 7'($urandom)};
		u_far.frame(v9, 8);
		u_far.ones(0, 0);
		e_sleep = 0;
		e_full = 1;
		clr; // address wakes
		chk(d, {23'h0, v9}); // byte loaded
		ctrl(32'hD);
		ctrl(32'h9);
		stat; // software clear
		$display("wakeup done");
		wr(`OFS_IRQ_CLR, 32'h7);
		wr(`OFS_IRQ_EN, 32'h1);
		u_far.frame(9'h03C, 8);
		u_far.ones(0, 0);
		ckirq(1);
		rd(`OFS_IRQ_STAT);
		chk(d, 32'h1);
		wr(`OFS_IRQ_EN, 32'h0);
		ckirq(0);
		wr(`OFS_IRQ_EN, 32'h1);
		ckirq(1);
		wr(`OFS_IRQ_CLR, 32'h1);
		ckirq(0);
		rd(`OFS_IRQ_STAT);
		chk(d, 32'h0);
		u_far.frame(9'h0C3, 8);
		u_far.ones(0, 0);
		rd(`OFS_STATUS);
		chk(d, 32'h5); // overrun set
		rd(`OFS_IRQ_STAT);
		chk(d, 32'h4); // overrun event
		rd(`OFS_DATA);
		chk(d, 32'h3C); // held data kept
		rd(`OFS_STATUS);
		chk(d, 32'h0); // overrun cleared
		$display("interrupts done");
		test_done;
	end
endmodule
